// file: dsq_pkg.sv
/*
 * Constants, state codes and counts for the dual-slope conversion sequencer.
 * Assumes a single conversion clock; no software-visible registers.
 */
// Behaviour
// - Each conversion runs offset null, signal integrate, then reference de-integrate.
// - Offset null grounds the input and closes the nulling feedback loop.
// - Offset null holds switches 1, 2 and 3 closed for 10,000 clocks.
// - Integrate opens switches 1-3 and closes switch 4 for 10,000 clocks, or 1,000 at low resolution.
// - Integrate length fixed by resolution: 1,000 or 10,000 clocks.
// - Polarity captured during integrate selects the reference driving back to zero.
// - De-integrate opens switch 4 and closes exactly one reference switch.
// - Negative input closes switch 5; positive input closes switch 6.
// - De-integrate moves the integrator input from signal to reference.
// - Clocks counted from de-integrate start to zero crossing give the magnitude.
// - Count equals the integrate clocks (10,000 or 1,000) times input over reference voltage.
// - Counter and timing support 20,000 counts full scale.

package dsq_pkg;
    // ************************************************************
    // Timing counts in conversion clocks
    // ************************************************************
    localparam int DSQ_CNT_W = 15;
    localparam logic [14:0] DSQ_NULL_CLKS = 15'h2710;
    localparam logic [14:0] DSQ_INT_CLKS_HI = 15'h2710;
    localparam logic [14:0] DSQ_INT_CLKS_LO = 15'h03E8;
    localparam logic [14:0] DSQ_FULL_SCALE = 15'h4E20;
    localparam logic [14:0] DSQ_CNT_RESET = 15'h0000;

    // ************************************************************
    // Sequencer states, one-hot
    // ************************************************************
    typedef enum logic [2:0] {
        DSQ_ST_NULL = 3'b001,
        DSQ_ST_INTEG = 3'b010,
        DSQ_ST_DEINT = 3'b100
    } dsq_state_t;
endpackage : dsq_pkg

// file: dsq_sync.sv
/*
 * Two-flop synchroniser for one level.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dsq_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : dsq_sync
`default_nettype wire

// file: dsq_seq.sv
/*
 * Dual-slope conversion sequencer: drives the analog switches, watches the
 * zero-crossing comparator, returns magnitude, polarity and over-range.
 * Assumes switches, integrator and comparator sit outside; comparator and
 * resolution inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module dsq_seq
    import dsq_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic RES_HIGH,
    input wire logic COMP_POS,
    output logic SW_NULL_1,
    output logic SW_NULL_2,
    output logic SW_NULL_3,
    output logic SW_SIGNAL_4,
    output logic SW_REF_5,
    output logic SW_REF_6,
    output logic [14:0] MAGNITUDE,
    output logic NEGATIVE,
    output logic OVER_RANGE,
    output logic RESULT_VALID
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic comp_s;
    logic res_s;

    dsq_sync u_comp (
        .clk(REF_CLK),
        .rst(RST),
        .d(COMP_POS),
        .q(comp_s)
    );

    dsq_sync u_res (
        .clk(REF_CLK),
        .rst(RST),
        .d(RES_HIGH),
        .q(res_s)
    );

    // ************************************************************
    // Sequencer state and phase counter
    // ************************************************************
    dsq_state_t state_q;
    dsq_state_t state_d;
    logic [14:0] cnt_q;
    logic [14:0] int_len_q;
    logic neg_q;
    logic last_null;
    logic last_int;
    logic crossed;
    logic full;
    // Next-cycle polarity and the end-of-measure strobe
    logic neg_d;
    logic done;

    function automatic logic at_end(input logic [14:0] c, input logic [14:0] len);
        at_end = (c == len - 15'h1);
    endfunction : at_end

    assign last_null = at_end(cnt_q, DSQ_NULL_CLKS);
    assign last_int = at_end(cnt_q, int_len_q);
    // Comparator sign flips opposite to captured polarity at zero
    assign crossed = (comp_s == neg_q);
    assign full = at_end(cnt_q, DSQ_FULL_SCALE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            DSQ_ST_NULL: begin
                if (last_null) begin
                    state_d = DSQ_ST_INTEG;
                end
            end
            DSQ_ST_INTEG: begin
                if (last_int) begin
                    state_d = DSQ_ST_DEINT;
                end
            end
            DSQ_ST_DEINT: begin
                if (crossed || full) begin
                    state_d = DSQ_ST_NULL;
                end
            end
            default: begin
                state_d = DSQ_ST_NULL;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_q <= DSQ_ST_NULL;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cnt_q <= DSQ_CNT_RESET;
        end else if (state_d != state_q) begin
            cnt_q <= DSQ_CNT_RESET;
        end else begin
            cnt_q <= cnt_q + 15'h1;
        end
    end

    // Length picked once per conversion, so a mid-phase change is harmless
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            int_len_q <= DSQ_INT_CLKS_HI;
        end else if (state_q == DSQ_ST_NULL && last_null) begin
            int_len_q <= res_s ? DSQ_INT_CLKS_HI : DSQ_INT_CLKS_LO;
        end
    end

    // Polarity taken at end of integrate
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            neg_q <= 1'b0;
        end else if (state_q == DSQ_ST_INTEG && last_int) begin
            neg_q <= ~comp_s;
        end
    end

    // ************************************************************
    // Switch drives, registered from next state
    // ************************************************************
    // On entry to de-integrate neg_q is not loaded yet, so take it live
    assign neg_d = (state_q == DSQ_ST_INTEG) ? ~comp_s : neg_q;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SW_NULL_1 <= 1'b1;
            SW_NULL_2 <= 1'b1;
            SW_NULL_3 <= 1'b1;
        end else begin
            SW_NULL_1 <= (state_d == DSQ_ST_NULL);
            SW_NULL_2 <= (state_d == DSQ_ST_NULL);
            SW_NULL_3 <= (state_d == DSQ_ST_NULL);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SW_SIGNAL_4 <= 1'b0;
        end else begin
            SW_SIGNAL_4 <= (state_d == DSQ_ST_INTEG);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SW_REF_5 <= 1'b0;
            SW_REF_6 <= 1'b0;
        end else begin
            // Exactly one of the pair while de-integrating
            SW_REF_5 <= (state_d == DSQ_ST_DEINT) && neg_d;
            SW_REF_6 <= (state_d == DSQ_ST_DEINT) && !neg_d;
        end
    end

    // ************************************************************
    // Result latch
    // ************************************************************
    // Crossing seen through the synchroniser, so counts read two clocks long
    assign done = (state_q == DSQ_ST_DEINT) && (crossed || full);

    // Count of de-integrate clocks is the result
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            MAGNITUDE <= DSQ_CNT_RESET;
        end else if (done) begin
            // A crossing on the last count still counts as in range
            MAGNITUDE <= crossed ? cnt_q : DSQ_FULL_SCALE;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            NEGATIVE <= 1'b0;
        end else if (done) begin
            NEGATIVE <= neg_q;
        end
    end

    // Over-range when the count ran out first
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            OVER_RANGE <= 1'b0;
        end else if (done) begin
            OVER_RANGE <= ~crossed;
        end
    end

    // One-cycle strobe with the new result
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RESULT_VALID <= 1'b0;
        end else begin
            RESULT_VALID <= done;
        end
    end
endmodule : dsq_seq
`default_nettype wire

// file: dsq_seq_monitor.sv
/* Checker for dsq_seq phase order, lengths and results.
   Bound to every dsq_seq; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dsq_seq_monitor
    import dsq_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic RES_HIGH,
    input wire logic SW_NULL_1,
    input wire logic SW_NULL_2,
    input wire logic SW_NULL_3,
    input wire logic SW_SIGNAL_4,
    input wire logic SW_REF_5,
    input wire logic SW_REF_6,
    input wire logic [14:0] MAGNITUDE,
    input wire logic NEGATIVE,
    input wire logic OVER_RANGE,
    input wire logic RESULT_VALID
);
    // ********
    // Phase length
    // ********
    logic [3:0] sw, sw_q;
    logic [14:0] cnt_q;
    logic [14:0] int_len;
    logic res_1_q, res_2_q, res_3_q, int_hi_q;
    assign sw = {SW_NULL_1, SW_SIGNAL_4, SW_REF_5, SW_REF_6};
    assign int_len = int_hi_q ? DSQ_INT_CLKS_HI : DSQ_INT_CLKS_LO;
    // Counts cycles since the switch pattern last changed
    always_ff @(posedge REF_CLK) begin
        sw_q <= sw;
        cnt_q <= RST ? 15'h0 : (sw == sw_q) ? cnt_q + 15'h1 : 15'h1;
    end
    // Resolution pin as seen at the end of nulling, two flops late
    always_ff @(posedge REF_CLK) begin
        res_1_q <= RES_HIGH;
        res_2_q <= res_1_q;
        res_3_q <= res_2_q;
        if ((sw != sw_q) && sw_q[3]) begin
            int_hi_q <= res_3_q;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence null_done; (sw != sw_q) && sw_q[3]; endsequence
    sequence int_done; (sw != sw_q) && sw_q[2]; endsequence
    sequence ref_done; $fell(SW_REF_5 | SW_REF_6); endsequence
    sequence fresh_count; RESULT_VALID && !OVER_RANGE; endsequence
    sequence over_count; RESULT_VALID && OVER_RANGE; endsequence
    a_phase_onehot: assert property ($onehot(sw))
        else $error("phase switches overlap");
    a_null_tied: assert property (SW_NULL_1 == SW_NULL_2 && SW_NULL_2 == SW_NULL_3)
        else $error("null switches differ");
    a_null_length: assert property (null_done |-> cnt_q == DSQ_NULL_CLKS && SW_SIGNAL_4)
        else $error("null length wrong");
    a_int_length: assert property (int_done |-> cnt_q == int_len)
        else $error("integrate length wrong");
    a_int_to_ref: assert property (int_done |-> !SW_SIGNAL_4 && SW_REF_5 != SW_REF_6)
        else $error("bad reference choice");
    a_ref_to_null: assert property (ref_done |-> RESULT_VALID && SW_NULL_1)
        else $error("no result at end");
    a_mag_count: assert property (fresh_count |-> MAGNITUDE == cnt_q - 15'h1)
        else $error("magnitude not count");
    a_over_full: assert property (over_count |-> MAGNITUDE == DSQ_FULL_SCALE)
        else $error("over-range magnitude");
    a_pol_ref: assert property (RESULT_VALID |-> NEGATIVE == $past(SW_REF_5))
        else $error("polarity mismatch");
endmodule : dsq_seq_monitor
bind dsq_seq dsq_seq_monitor u_dsq_seq_monitor (.REF_CLK(REF_CLK), .RST(RST),
    .RES_HIGH(RES_HIGH), .SW_NULL_1(SW_NULL_1), .SW_NULL_2(SW_NULL_2), .SW_NULL_3(SW_NULL_3),
    .SW_SIGNAL_4(SW_SIGNAL_4), .SW_REF_5(SW_REF_5), .SW_REF_6(SW_REF_6),
    .MAGNITUDE(MAGNITUDE), .NEGATIVE(NEGATIVE), .OVER_RANGE(OVER_RANGE),
    .RESULT_VALID(RESULT_VALID));
`default_nettype wire

// file: dsq_integ_model.sv
/* Integrator and zero-crossing comparator model.
   Assumes switch inputs are active high. */
`timescale 1ns/1ps
`default_nettype none
module dsq_integ_model (
    input wire logic clk,
    input wire logic sw_null,
    input wire logic sw_sig,
    input wire logic sw_ref_up,
    input wire logic sw_ref_dn,
    input wire logic signed [31:0] analog_input_voltage,
    input wire logic signed [31:0] vref,
    output logic comp_pos
);
    int v_q;
    // Integer charge; moves off the design's sampling edge
    always_ff @(negedge clk) begin
        if (sw_null) v_q <= 0;
        else if (sw_sig) v_q <= v_q + analog_input_voltage;
        else if (sw_ref_up) v_q <= v_q + vref;
        else if (sw_ref_dn) v_q <= v_q - vref;
    end
    assign comp_pos = v_q > 0;
endmodule : dsq_integ_model
`default_nettype wire

// file: test_dsq_seq.sv
/* Self-checking bench for dsq_seq with integrator model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
`default_nettype none
module test_dsq_seq;
    logic REF_CLK = 1'b0, RST = 1'b1, RES_HIGH = 1'b0;
    logic COMP_POS, SW_NULL_1, SW_NULL_2, SW_NULL_3, SW_SIGNAL_4, SW_REF_5, SW_REF_6;
    logic NEGATIVE, OVER_RANGE, RESULT_VALID;
    logic [14:0] MAGNITUDE;
    logic signed [31:0] analog_input_voltage = 32'sh0, vref = 32'shA;
    int fails = 0, checked = 0;
    initial forever #12.5 REF_CLK = ~REF_CLK;
    dsq_seq u_dsq_seq (.REF_CLK(REF_CLK), .RST(RST), .RES_HIGH(RES_HIGH), .COMP_POS(COMP_POS),
        .SW_NULL_1(SW_NULL_1), .SW_NULL_2(SW_NULL_2), .SW_NULL_3(SW_NULL_3),
        .SW_SIGNAL_4(SW_SIGNAL_4), .SW_REF_5(SW_REF_5), .SW_REF_6(SW_REF_6),
        .MAGNITUDE(MAGNITUDE), .NEGATIVE(NEGATIVE), .OVER_RANGE(OVER_RANGE),
        .RESULT_VALID(RESULT_VALID));
    dsq_integ_model u_dsq_integ_model (.clk(REF_CLK), .sw_null(SW_NULL_1),
        .sw_sig(SW_SIGNAL_4), .sw_ref_up(SW_REF_5), .sw_ref_dn(SW_REF_6),
        .analog_input_voltage(analog_input_voltage), .vref(vref), .comp_pos(COMP_POS));
    task automatic results;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    task automatic check(input logic ok, input string what);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask : check
    // One conversion, judged when its result pulse shows
    task automatic conv(input logic res, input int v, lo, hi, input logic neg, ovr);
        int n;
        @(negedge REF_CLK);
        RES_HIGH = res;
        analog_input_voltage = v;
        n = 0;
        while (RESULT_VALID !== 1'b1 && n < 45000) begin
            @(negedge REF_CLK);
            n++;
        end
        check(n < 45000, "no result");
        check(NEGATIVE === neg && OVER_RANGE === ovr, "flags");
        check(MAGNITUDE >= lo && MAGNITUDE <= hi, "magnitude");
    endtask : conv
    task automatic pos_short;
        conv(1'b0, 3, 300, 304, 1'b0, 1'b0);
    endtask : pos_short
    task automatic neg_short;
        conv(1'b0, -4, 400, 405, 1'b1, 1'b0);
    endtask : neg_short
    // Full-length integrate with a crossing inside the range
    task automatic pos_long;
        conv(1'b1, 2, 2000, 2004, 1'b0, 1'b0);
    endtask : pos_long
    task automatic over_long;
        conv(1'b1, 30, 20000, 20000, 1'b0, 1'b1);
    endtask : over_long
    initial begin
        repeat (10) @(negedge REF_CLK);
        RST = 1'b0;
        check(SW_NULL_1 === 1'b1 && SW_SIGNAL_4 === 1'b0 && MAGNITUDE === 15'h0, "reset");
        pos_short();
        neg_short();
        pos_long();
        over_long();
        results();
    end
    // Four conversions need about 85000 cycles
    initial begin
        #(95000 * 25);
        fails++;
        results();
    end
endmodule : test_dsq_seq
`default_nettype wire
